/* shared/paia_pkg.sv */
/*
 * Package for the port alias and indirect access register block: register
 * offsets, field positions, reset values and the structs that carry the
 * decoded I2C target traffic between the block and its neighbours.
 * Assumes the I2C target front end delivers whole bytes on ref_clk.
 */
package paia_pkg;

	// Main register space offsets
	localparam logic [7:0] REG_PORT_SEL   = 8'h4C;
	localparam logic [7:0] REG_IND_CTL    = 8'hB0;
	localparam logic [7:0] REG_IND_OFS    = 8'hB1;
	localparam logic [7:0] REG_IND_DATA   = 8'hB2;
	localparam logic [7:0] REG_ALIAS2     = 8'hFA;
	localparam logic [7:0] REG_ALIAS3     = 8'hFB;

	// Field widths and positions
	localparam int         PORT_W         = 2;
	localparam int         ALIAS_W        = 7;
	localparam int         ALIAS_LSB      = 1;
	localparam int         IND_BLK_W      = 2;
	localparam int         CTL_AUTOINC    = 0;
	localparam int         CTL_BLK_LSB    = 1;
	localparam int         IND_OFS_W      = 8;
	localparam int         IND_BLOCKS     = 4;
	localparam int         IND_DEPTH      = 256;

	// Port numbers served by the alias decoders
	localparam logic [1:0] PORT_TWO       = 2'h2;
	localparam logic [1:0] PORT_THREE     = 2'h3;

	// Reset values
	localparam logic [1:0] RST_PORT_SEL   = 2'h0;
	localparam logic [6:0] RST_ALIAS      = 7'h00;
	localparam logic [1:0] RST_IND_BLK    = 2'h0;
	localparam logic       RST_AUTOINC    = 1'b0;
	localparam logic [7:0] RST_IND_OFS    = 8'h00;

	// Address phase from the I2C target: one pulse per start/restart
	typedef struct packed {
		logic       valid;
		logic [6:0] dev;
	} paia_addr_t;

	// Claim answer to an address phase
	typedef struct packed {
		logic valid;
		logic ack;
	} paia_ack_t;

	// One register byte access after a claimed address
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] reg_addr;
		logic [7:0] wdata;
	} paia_acc_t;

	// Read answer back to the I2C target
	typedef struct packed {
		logic       valid;
		logic [7:0] rdata;
	} paia_rsp_t;

	// Forwarded access to shared and port-specific registers
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [1:0] port;
		logic [7:0] reg_addr;
		logic [7:0] wdata;
	} paia_ext_t;

	// Access to the secondary register blocks
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [1:0] blk;
		logic [7:0] ofs;
		logic [7:0] wdata;
	} paia_mem_t;

	// Where a pending read answer comes from
	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_LOCAL,
		SRC_EXT,
		SRC_MEM
	} paia_src_t;

	// Whole state of the main module
	typedef struct packed {
		paia_ack_t  ack;
		logic       sess_alias;
		logic [1:0] sess_port;
		logic [1:0] port_sel;
		logic [6:0] alias2;
		logic [6:0] alias3;
		logic [1:0] ind_blk;
		logic       autoinc;
		logic [7:0] ind_ofs;
		paia_ext_t  ext;
		paia_src_t  pend_src;
		logic [7:0] pend_local;
		paia_rsp_t  rsp;
	} paia_state_t;

endpackage

/* verilog/paia_ind_mem.sv */
/*
 * Storage for the secondary register blocks reached through the indirect
 * window. One byte per access, read data registered one edge later.
 * Assumes the main module never reads and writes in the same cycle.
 */
`timescale 1ns/1ns
module paia_ind_mem
	import paia_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire paia_mem_t  req,
	output logic [7:0]      rdata
);

	// Blocks laid end to end; no reset, contents are what software wrote
	logic [7:0] mem [IND_BLOCKS*IND_DEPTH];
	logic [9:0] idx;

	assign idx = {req.blk, req.ofs};

	// Byte write at the selected block and offset
	always_ff @(posedge ref_clk)
	begin
		if (req.valid && req.write)
			mem[idx] <= req.wdata;
	end

	// Registered read; holds its last value between reads
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			rdata <= 8'h00;
		else if (req.valid && !req.write)
			rdata <= mem[idx];
	end

endmodule

/* verilog/paia_regs.sv */
/*
 * Alias decoders for receive ports 2 and 3, the port select register and
 * the indirect access window into the secondary register blocks.
 * Assumes an I2C target front end on ref_clk that presents each address
 * phase and each register byte as one-cycle pulses, and an outer register
 * file that answers a forwarded read combinationally in the same cycle.
 */
`timescale 1ns/1ns
// How it works
// (RL1) A nonzero alias in bits 7:1 of the port-2 register claims port 2.
// (RL2) A nonzero alias in bits 7:1 of the port-3 register claims port 3.
// (RL3) A zero port-2 alias field turns that decoder off.
// (RL4) A zero port-3 alias field turns that decoder off.
// (RL5) Accesses through an alias still reach all shared registers.
// (RL6) An alias selects its own port page whatever the port select holds.
// (RL7) Without an alias the port select register at 0x4C picks the page.
// (RL8) Indirect control, offset and data registers sit at 0xB0 to 0xB2.
// (RL9) The control register chooses which secondary block is targeted.
// (RL10) The offset register holds where the next data access lands.
// (RL11) A data write stores its byte at the chosen block and offset.
// (RL12) A data read returns the byte at the chosen block and offset.
// (RL13) With auto-increment on, each data access advances the offset by one.
// (RL14) With auto-increment on, repeated writes fill consecutive offsets.
// (RL15) With auto-increment on, repeated reads return consecutive offsets.
// (RL16) With auto-increment off, data accesses leave the offset alone.
module paia_regs
	import paia_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic [6:0] dev_addr,
	input  wire paia_addr_t addr_in,
	output paia_ack_t       ack_out,
	input  wire paia_acc_t  acc_in,
	output paia_rsp_t       rsp_out,
	output paia_ext_t       ext_out,
	input  wire logic [7:0] ext_rdata
);

	paia_state_t st_q;
	paia_state_t st_d;
	paia_mem_t   mem_req;
	logic [7:0]  mem_rdata;
	logic        hit2;
	logic        hit3;
	logic        is_data;
	logic        is_local;

	// Alias match; a zero alias never matches, which disables the decoder
	function automatic logic alias_hit(input logic [6:0] alias_v,
		input logic [6:0] dev);
		alias_hit = (alias_v != RST_ALIAS) && (alias_v == dev);
	endfunction

	// Local registers answered here, everything else goes outward
	function automatic logic owns_reg(input logic [7:0] a);
		owns_reg = (a == REG_PORT_SEL) || (a == REG_IND_CTL) ||
			(a == REG_IND_OFS) || (a == REG_IND_DATA) ||
			(a == REG_ALIAS2) || (a == REG_ALIAS3);
	endfunction

	assign hit2     = alias_hit(st_q.alias2, addr_in.dev); // [RL1] [RL3]
	assign hit3     = alias_hit(st_q.alias3, addr_in.dev); // [RL2] [RL4]
	assign is_data  = acc_in.reg_addr == REG_IND_DATA;       // [RL8]
	assign is_local = owns_reg(acc_in.reg_addr);             // [RL8]

	// Secondary block storage, fed combinationally from the current request and state so reads return in time
	paia_ind_mem u_mem (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.req     (mem_req),
		.rdata   (mem_rdata)
	);

	// Next-state logic for claims, register writes and read answers
	always_comb
	begin
		logic [7:0] ctl_rd;
		logic [7:0] loc_rd;
		ctl_rd = 8'h00;
		loc_rd = 8'h00;
		st_d = st_q;
		st_d.ack = '0;
		st_d.ext = '0;
		st_d.rsp = '0;
		st_d.pend_src = SRC_NONE;
		mem_req = '0;

		// Address phase: main address first, then port 2, then port 3
		if (addr_in.valid)
		begin
			st_d.ack.valid = 1'b1;
			if (addr_in.dev == dev_addr)
			begin
				st_d.ack.ack = 1'b1;
				st_d.sess_alias = 1'b0;
			end
			else if (hit2)
			begin
				st_d.ack.ack = 1'b1; // [RL1]
				st_d.sess_alias = 1'b1;
				st_d.sess_port = PORT_TWO; // [RL6]
			end
			else if (hit3)
			begin
				st_d.ack.ack = 1'b1; // [RL2]
				st_d.sess_alias = 1'b1;
				st_d.sess_port = PORT_THREE; // [RL6]
			end
		end

		// Control register read image
		ctl_rd[CTL_AUTOINC] = st_q.autoinc;
		ctl_rd[CTL_BLK_LSB +: IND_BLK_W] = st_q.ind_blk;

		// Local read mux; reserved bits read as zero
		case (acc_in.reg_addr)
			REG_PORT_SEL: loc_rd = {6'h00, st_q.port_sel};
			REG_IND_CTL:  loc_rd = ctl_rd;
			REG_IND_OFS:  loc_rd = st_q.ind_ofs;
			REG_ALIAS2:   loc_rd = {st_q.alias2, 1'b0};
			REG_ALIAS3:   loc_rd = {st_q.alias3, 1'b0};
			default:      loc_rd = 8'h00;
		endcase

		// Register access
		if (acc_in.valid)
		begin
			if (is_data)
			begin
				// Data window hits the selected block at the held offset
				mem_req.valid = 1'b1; // [RL11] [RL12]
				mem_req.write = acc_in.write;
				mem_req.blk = st_q.ind_blk; // [RL9]
				mem_req.ofs = st_q.ind_ofs; // [RL10]
				mem_req.wdata = acc_in.wdata;
				if (st_q.autoinc)
					st_d.ind_ofs = st_q.ind_ofs + 8'h01; // [RL13] [RL14] [RL15]
				else
					st_d.ind_ofs = st_q.ind_ofs; // [RL16]
				if (!acc_in.write)
					st_d.pend_src = SRC_MEM;
			end
			else if (is_local)
			begin
				if (acc_in.write)
				begin
					case (acc_in.reg_addr)
						REG_PORT_SEL: st_d.port_sel = acc_in.wdata[PORT_W-1:0]; // [RL7]
						REG_IND_CTL:
						begin
							st_d.autoinc = acc_in.wdata[CTL_AUTOINC]; // [RL13]
							st_d.ind_blk = acc_in.wdata[CTL_BLK_LSB +: IND_BLK_W]; // [RL9]
						end
						REG_IND_OFS:  st_d.ind_ofs = acc_in.wdata; // [RL10]
						REG_ALIAS2:   st_d.alias2 = acc_in.wdata[ALIAS_LSB +: ALIAS_W]; // [RL1]
						REG_ALIAS3:   st_d.alias3 = acc_in.wdata[ALIAS_LSB +: ALIAS_W]; // [RL2]
						default:      st_d.ind_ofs = st_q.ind_ofs;
					endcase
				end
				else
				begin
					st_d.pend_src = SRC_LOCAL;
					st_d.pend_local = loc_rd;
				end
			end
			else
			begin
				// Shared and port registers; the alias page overrides port select
				st_d.ext.valid = 1'b1; // [RL5]
				st_d.ext.write = acc_in.write;
				st_d.ext.reg_addr = acc_in.reg_addr;
				st_d.ext.wdata = acc_in.wdata;
				st_d.ext.port = st_q.sess_alias ? st_q.sess_port // [RL6]
					: st_q.port_sel; // [RL7]
				if (!acc_in.write)
					st_d.pend_src = SRC_EXT;
			end
		end

		// Second stage: pick the answer source of the pending read
		case (st_q.pend_src)
			SRC_LOCAL:
			begin
				st_d.rsp.valid = 1'b1;
				st_d.rsp.rdata = st_q.pend_local;
			end
			SRC_EXT:
			begin
				st_d.rsp.valid = 1'b1;
				st_d.rsp.rdata = ext_rdata;
			end
			SRC_MEM:
			begin
				st_d.rsp.valid = 1'b1; // [RL12]
				st_d.rsp.rdata = mem_rdata;
			end
			default:
			begin
				st_d.rsp.valid = 1'b0;
			end
		endcase
	end

	// State register; configuration fields start from their named reset values, the rest from zero
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q.ack        <= '0;
			st_q.sess_alias <= 1'b0;
			st_q.sess_port  <= RST_PORT_SEL;
			st_q.port_sel   <= RST_PORT_SEL;
			st_q.alias2     <= RST_ALIAS;
			st_q.alias3     <= RST_ALIAS;
			st_q.ind_blk    <= RST_IND_BLK;
			st_q.autoinc    <= RST_AUTOINC;
			st_q.ind_ofs    <= RST_IND_OFS;
			st_q.ext        <= '0;
			st_q.pend_src   <= SRC_NONE;
			st_q.pend_local <= 8'h00;
			st_q.rsp        <= '0;
		end
		else
			st_q <= st_d;
	end

	// Outputs straight from the state register
	assign ack_out = st_q.ack;
	assign rsp_out = st_q.rsp;
	assign ext_out = st_q.ext;

	// Port 2 alias claims and opens the port 2 page
	a_alias2_claim: assert property ( // [RL1]
		@(posedge ref_clk) disable iff (!resetn)
		addr_in.valid && hit2 && addr_in.dev != dev_addr
		|=> ack_out.ack && st_q.sess_alias && st_q.sess_port == PORT_TWO)
		else $error("port 2 alias not claimed");

	// Port 3 alias claims and opens the port 3 page
	a_alias3_claim: assert property ( // [RL2]
		@(posedge ref_clk) disable iff (!resetn)
		addr_in.valid && hit3 && !hit2 && addr_in.dev != dev_addr
		|=> ack_out.ack && st_q.sess_port == PORT_THREE)
		else $error("port 3 alias not claimed");

	// Zero port 2 alias never claims any address other than the main and port 3 ones
	a_alias2_off: assert property ( // [RL3]
		@(posedge ref_clk) disable iff (!resetn)
		addr_in.valid && st_q.alias2 == RST_ALIAS && addr_in.dev != dev_addr
		&& addr_in.dev != st_q.alias3 |=> ack_out.valid && !ack_out.ack)
		else $error("disabled port 2 alias claimed");

	// Zero port 3 alias never claims
	a_alias3_off: assert property ( // [RL4]
		@(posedge ref_clk) disable iff (!resetn)
		addr_in.valid && st_q.alias3 == RST_ALIAS && addr_in.dev != dev_addr
		&& addr_in.dev != st_q.alias2 |=> !ack_out.ack)
		else $error("disabled port 3 alias claimed");

	// Alias session forwards to its own page
	a_alias_page: assert property ( // [RL5] [RL6]
		@(posedge ref_clk) disable iff (!resetn)
		acc_in.valid && !is_local && st_q.sess_alias
		|=> ext_out.valid && ext_out.port == $past(st_q.sess_port))
		else $error("alias access on wrong page");

	// Plain session follows the port select
	a_sel_page: assert property ( // [RL7]
		@(posedge ref_clk) disable iff (!resetn)
		acc_in.valid && !is_local && !st_q.sess_alias
		|=> ext_out.valid && ext_out.port == $past(st_q.port_sel))
		else $error("port select not applied");

	// Local window registers are answered here and never forwarded
	a_local_kept: assert property ( // [RL8]
		@(posedge ref_clk) disable iff (!resetn)
		acc_in.valid && is_local |=> !ext_out.valid)
		else $error("local register forwarded");

	// Data access goes to the block at the held offset
	a_data_target: assert property ( // [RL11] [RL14]
		@(posedge ref_clk) disable iff (!resetn)
		acc_in.valid && is_data |-> mem_req.valid
		&& mem_req.ofs == st_q.ind_ofs && mem_req.blk == st_q.ind_blk
		&& mem_req.write == acc_in.write)
		else $error("indirect access misdirected");

	// Offset advances by exactly one with auto-increment
	a_ofs_inc: assert property ( // [RL13] [RL15]
		@(posedge ref_clk) disable iff (!resetn)
		acc_in.valid && is_data && st_q.autoinc
		|=> st_q.ind_ofs == $past(st_q.ind_ofs) + 8'h01)
		else $error("offset did not advance");

	// Offset holds without auto-increment
	a_ofs_hold: assert property ( // [RL16]
		@(posedge ref_clk) disable iff (!resetn)
		acc_in.valid && is_data && !st_q.autoinc |=> $stable(st_q.ind_ofs))
		else $error("offset moved without auto-increment");

	// Every read answers exactly two edges later, reads may be pipelined
	a_read_answer: assert property ( // [RL12]
		@(posedge ref_clk) disable iff (!resetn)
		acc_in.valid && !acc_in.write |-> ##2 rsp_out.valid)
		else $error("read answer missing");

endmodule

/* testbench/paia_ext_model.sv */
/*
 * Outer register file model: answers forwarded reads from the block.
 * Assumes reads are answered combinationally in the cycle of the request.
 */
`timescale 1ns/1ns
module paia_ext_model
	import paia_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire paia_ext_t ext,
	output logic [7:0]     rdata
);
	logic [7:0] idle_q = 8'h00;

	// Idle pattern moves every cycle so a stale sample never looks right
	always @(posedge ref_clk)
		idle_q <= idle_q + 8'h3B;

	// Answer encodes page and offset, so a wrong page shows in the data
	assign rdata = (ext.valid && !ext.write) ?
		{ext.port, ext.reg_addr[5:0]} : idle_q;
endmodule

/* testbench/test_port_alias_and_indirect_access.sv */
/*
 * Self-checking bench for paia_regs: address phases, register accesses,
 * alias decoding and the indirect window, with a queue scoreboard.
 * Assumes the outer register file model answers forwarded reads.
 */
`timescale 1ns/1ns
module test_port_alias_and_indirect_access
	import paia_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [6:0]  dev_addr = 7'h30;
	paia_addr_t  addr_in = '0;
	paia_ack_t   ack_out;
	paia_acc_t   acc_in = '0;
	paia_rsp_t   rsp_out;
	paia_ext_t   ext_out;
	logic [7:0]  ext_rdata;
	logic [15:0] aq[$];
	logic [15:0] rq[$];
	logic [31:0] eq[$];
	logic [7:0]  mem [4][256];
	logic [31:0] seed = 32'd31459;
	int          mismatches = 0;
	int          n_compared = 0;
	logic [1:0]  pg = 2'h0;
	logic [7:0]  o;
	logic [7:0]  v;

	always #2 ref_clk = ~ref_clk;

	paia_regs i_dut (.ref_clk(ref_clk), .resetn(resetn),
		.dev_addr(dev_addr), .addr_in(addr_in), .ack_out(ack_out),
		.acc_in(acc_in), .rsp_out(rsp_out), .ext_out(ext_out),
		.ext_rdata(ext_rdata));

	paia_ext_model i_ext (.ref_clk(ref_clk), .ext(ext_out),
		.rdata(ext_rdata));

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task results;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One address phase; the claim answer is noted for the monitor
	task phase(input logic [6:0] d, input logic a);
		@(posedge ref_clk);
		addr_in <= '{1'b1, d};
		aq.push_back({15'h0, a});
		@(posedge ref_clk);
		addr_in <= '0;
	endtask

	// One register byte; local reads expect e, others the model's answer
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] e);
		logic loc;
		loc = a == REG_PORT_SEL || a == REG_IND_CTL || a == REG_IND_OFS ||
			a == REG_IND_DATA || a == REG_ALIAS2 || a == REG_ALIAS3;
		@(posedge ref_clk);
		acc_in <= '{1'b1, w, a, d};
		if (!loc)
			eq.push_back({13'h0, w, pg, a, d});
		if (!w)
			rq.push_back({8'h0, loc ? e : {pg, a[5:0]}});
		@(posedge ref_clk);
		acc_in <= '0;
	endtask

	// Monitor on the falling edge, where registered outputs have settled
	always @(negedge ref_clk)
	begin
		if (ack_out.valid)
			chk({15'h0, ack_out.ack}, aq.size() ? aq.pop_front() : 16'hFFFF);
		if (rsp_out.valid)
			chk({8'h0, rsp_out.rdata}, rq.size() ? rq.pop_front() : 16'hFFFF);
		if (ext_out.valid)
			chk({13'h0, ext_out.write, ext_out.port, ext_out.reg_addr,
				ext_out.wdata}, eq.size() ? eq.pop_front() : 32'hFFFFFFFF);
	end

	// Main sequence
	initial
	begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		phase(7'h30, 1'b1);
		acc(1'b0, REG_PORT_SEL, 8'h00, 8'h00);
		acc(1'b0, REG_IND_CTL, 8'h00, 8'h00);
		acc(1'b0, REG_IND_OFS, 8'h00, 8'h00);
		acc(1'b0, REG_ALIAS2, 8'h00, 8'h00);
		acc(1'b0, REG_ALIAS3, 8'h00, 8'h00);
		$display("test reset done");
		acc(1'b1, REG_ALIAS2, 8'h55, 8'h00);
		acc(1'b0, REG_ALIAS2, 8'h00, 8'h54);
		acc(1'b1, REG_ALIAS3, 8'h67, 8'h00);
		acc(1'b0, REG_ALIAS3, 8'h00, 8'h66);
		acc(1'b1, REG_PORT_SEL, 8'hFD, 8'h00);
		acc(1'b0, REG_PORT_SEL, 8'h00, 8'h01);
		pg = 2'h1;
		acc(1'b0, 8'h10, 8'h00, 8'h00);
		phase(7'h2A, 1'b1);
		pg = 2'h2;
		acc(1'b0, 8'h10, 8'h00, 8'h00);
		acc(1'b1, 8'h20, 8'h12, 8'h00);
		phase(7'h11, 1'b0);
		acc(1'b0, 8'h21, 8'h00, 8'h00);
		phase(7'h33, 1'b1);
		pg = 2'h3;
		acc(1'b0, 8'h10, 8'h00, 8'h00);
		acc(1'b1, REG_ALIAS2, 8'h00, 8'h00);
		acc(1'b1, REG_ALIAS3, 8'h00, 8'h00);
		phase(7'h2A, 1'b0);
		phase(7'h33, 1'b0);
		phase(7'h00, 1'b0);
		phase(7'h30, 1'b1);
		pg = 2'h1;
		acc(1'b0, 8'h10, 8'h00, 8'h00);
		$display("test alias done");
		// Host order: block, offset, then data; the offset wraps at the top
		for (int b = 0; b < 4; b++)
		begin
			o = 8'hFD + 8'(b);
			acc(1'b1, REG_IND_CTL, {5'h0, b[1:0], 1'b1}, 8'h00);
			acc(1'b0, REG_IND_CTL, 8'h00, {5'h0, b[1:0], 1'b1});
			acc(1'b1, REG_IND_OFS, o, 8'h00);
			for (int k = 0; k < 3; k++)
			begin
				v = rnd();
				mem[b][8'(o + k)] = v;
				acc(1'b1, REG_IND_DATA, v, 8'h00);
			end
			acc(1'b0, REG_IND_OFS, 8'h00, o + 8'h3);
			acc(1'b1, REG_IND_OFS, o, 8'h00);
			for (int k = 0; k < 3; k++)
				acc(1'b0, REG_IND_DATA, 8'h00, mem[b][8'(o + k)]);
			acc(1'b1, REG_IND_CTL, {5'h0, b[1:0], 1'b0}, 8'h00);
			acc(1'b1, REG_IND_OFS, o, 8'h00);
			repeat (2) acc(1'b0, REG_IND_DATA, 8'h00, mem[b][o]);
			acc(1'b0, REG_IND_OFS, 8'h00, o);
		end
		$display("test indirect done");
		repeat (4) @(posedge ref_clk);
		chk(16'(aq.size() + rq.size() + eq.size()), 16'h0000);
		results;
	end

	// Watchdog: the sequence needs well under a tenth of this span
	initial
	begin
		#40000;
		mismatches++;
		results;
	end
endmodule
